/* verilog/hdrmc_pkg.sv */
package hdrmc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00; // enable
    localparam logic [7:0] ADDR_STATUS = 8'h04; // sticky, write one to clear
    localparam logic [7:0] ADDR_MASK = 8'h08; // interrupt mask
    localparam logic [7:0] ADDR_CAUSE = 8'h0C; // failures of last checked message
    localparam logic [7:0] ADDR_GAMUT = 8'h10; // last gamut selector and class
    localparam logic [7:0] ADDR_MDCV = 8'h14; // volume message held

    // field positions
    localparam int CTRL_EN = 0;
    localparam int ST_NONCONF = 0;
    localparam int ST_FWD = 1;
    localparam int ST_AVC = 2;
    localparam int ST_TABLE = 3;
    localparam int GAMUT_CLASS_LSB = 8;
    localparam int CB_MODE = 0;
    localparam int CB_MAJOR = 1;
    localparam int CB_MINOR = 2;
    localparam int CB_PICINFO = 3;
    localparam int CB_EXT = 4;
    localparam int CB_TMAX = 5;
    localparam int CB_TMIN = 6;
    localparam int CB_CHROMA = 7;
    localparam int CB_LUMA = 8;
    localparam int CB_GAMUT = 9;
    localparam int N_CAUSE = 10;

    // values after reset
    localparam logic CTRL_EN_RST = 1'h1;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;

    // required field values and ranges
    localparam logic [7:0] REQ_MODE = 8'h01;
    localparam logic [3:0] REQ_MAJOR = 4'h1;
    localparam logic [3:0] REQ_MINOR = 4'h0;
    localparam logic [15:0] REQ_TMAX = 16'h0064;
    localparam logic [15:0] REQ_TMIN = 16'h0000;
    localparam logic [15:0] COEF_ZERO = 16'h0000;
    localparam logic [7:0] GM_BASE_HI = 8'h01;
    localparam logic [7:0] GM_P3 = 8'h04;
    localparam logic [7:0] GM_2020 = 8'h05;
    localparam logic [7:0] GM_USER_LO = 8'h40;
    localparam logic [7:0] GM_USER_HI = 8'h7F;
    localparam logic CARRIAGE_PARAM = 1'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // array sizes
    localparam int N_CHROMA = 2;
    localparam int N_LUMA = 3;

    // gamut preset classes
    typedef enum logic [2:0] {
        GMC_BASE, GMC_P3_TO_709, GMC_2020_TO_709, GMC_USER, GMC_INVALID
    } hdrmc_gamut_e_t;

    // mastering display colour volume contents
    typedef struct packed {
        logic [5:0][15:0] primaries;
        logic [1:0][15:0] whitePoint;
        logic [31:0] maxLum;
        logic [31:0] minLum;
    } hdrmc_mdcv_t;

    // one parsed reconstruction metadata message
    typedef struct packed {
        logic inAvc;
        logic carriageModeSel;
        logic [7:0] reconModeCode;
        logic [3:0] specMajorRev;
        logic [3:0] specMinorRev;
        logic codedPicInfoPresent;
        logic [7:0] codedPrimaries;
        logic [15:0] codedMaxLum;
        logic [15:0] codedMinLum;
        logic targetInfoPresent;
        logic [15:0] targetMaxLum;
        logic [15:0] targetMinLum;
        logic [N_CHROMA-1:0][15:0] chromaIntoLumaCoef;
        logic [N_LUMA-1:0][15:0] lumaWeightCoef;
        logic [7:0] gamutMapMode;
        logic extPresentFlag;
        logic [5:0] extSixBitField;
        logic [7:0] extPayloadCount;
        logic mdcvPresent;
        hdrmc_mdcv_t mdcv;
    } hdrmc_msg_t;

    // bus master to slave
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } hdrmc_axi_req_t;

    // slave to bus master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } hdrmc_axi_rsp_t;

endpackage : hdrmc_pkg

/* verilog/hdrmc_conformance.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module hdrmc_conformance
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus
    input wire hdrmc_pkg::hdrmc_axi_req_t axiReq,
    output wire hdrmc_pkg::hdrmc_axi_rsp_t axiRsp,
    // from the bitstream parser
    input wire logic msgValid,
    input wire hdrmc_pkg::hdrmc_msg_t msgIn,
    input wire logic mdcvValid,
    input wire hdrmc_pkg::hdrmc_mdcv_t mdcvIn,
    // to the display interface transmitter
    output wire logic msgOutValid,
    output wire hdrmc_pkg::hdrmc_msg_t msgOut,
    output wire logic checkFail,
    output wire logic irq
);
    import hdrmc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        hdrmc_axi_rsp_t rsp; // bus answer, straight out
        logic awHeld; // write address taken
        logic [7:0] awAddr;
        logic wHeld; // write data taken
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic ctrlEnable; // checker on
        logic [3:0] status; // sticky events
        logic [3:0] mask; // interrupt mask
        logic [N_CAUSE-1:0] cause; // last failures
        logic [7:0] gamutLast; // last selector seen
        hdrmc_gamut_e_t gamutClass; // its decoded class
        logic mdcvHeld; // a volume message was received
        hdrmc_mdcv_t mdcv; // its contents
        hdrmc_msg_t msgOut; // message for the transmitter
        logic msgOutValid;
        logic checkFail;
        logic irq;
    } hdrmc_state_t;

    hdrmc_state_t st; // registered state
    hdrmc_state_t next_st; // its next value
    logic [N_CHROMA-1:0] chromaNz; // nonzero chroma entries
    logic [N_LUMA-1:0] lumaNz; // nonzero luma entries

    // ------------------------------------------------------------
    // coefficient checks, one comparator per entry
    // ------------------------------------------------------------
    genvar gi;
    for (gi = 0; gi < N_CHROMA; gi++)
    begin : gChroma
        // each chroma injection entry must be zero
        assign chromaNz[gi] = (msgIn.chromaIntoLumaCoef[gi] != COEF_ZERO);
    end
    for (gi = 0; gi < N_LUMA; gi++)
    begin : gLuma
        // each luma weighting entry must be zero
        assign lumaNz[gi] = (msgIn.lumaWeightCoef[gi] != COEF_ZERO);
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // gamut selector to preset class
    function automatic hdrmc_gamut_e_t decodeGamut(input logic [7:0] code);
        hdrmc_gamut_e_t cls;
        cls = GMC_INVALID;
        if (code <= GM_BASE_HI)
        begin
            cls = GMC_BASE;
        end
        else if (code == GM_P3)
        begin
            cls = GMC_P3_TO_709;
        end
        else if (code == GM_2020)
        begin
            cls = GMC_2020_TO_709;
        end
        else if (code >= GM_USER_LO && code <= GM_USER_HI)
        begin
            cls = GMC_USER;
        end
        return cls; // everything else stays invalid
    endfunction : decodeGamut

    // word-aligned address compare, low two bits ignored
    function automatic logic addrIs(input logic [7:0] a, input logic [7:0] reg_addr);
        return a[7:2] == reg_addr[7:2];
    endfunction : addrIs

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [N_CAUSE-1:0] fails;
        hdrmc_gamut_e_t gClass;
        logic [3:0] setBits;
        logic [3:0] clrBits;
        logic [31:0] rd;
        logic hit;
        hdrmc_mdcv_t mdcvNow;
        logic mdcvNowHeld;
        hdrmc_msg_t fwdMsg;
        fails = '0;
        gClass = GMC_INVALID;
        setBits = 4'h0;
        clrBits = 4'h0;
        rd = 32'h00000000;
        hit = 1'b0;
        mdcvNow = st.mdcv;
        mdcvNowHeld = st.mdcvHeld;
        fwdMsg = msgIn;
        next_st = st;
        next_st.msgOutValid = 1'b0; // pulses
        next_st.checkFail = 1'b0;

        // --- write channel: address and data in either order ---
        if (axiReq.awvalid && st.rsp.awready)
        begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && st.rsp.wready)
        begin
            next_st.wHeld = 1'b1;
            next_st.wData = axiReq.wdata;
            next_st.wStrb = axiReq.wstrb;
        end
        // response retired
        if (st.rsp.bvalid && axiReq.bready)
        begin
            next_st.rsp.bvalid = 1'b0;
        end
        // both halves in hand: perform the write
        if (next_st.awHeld && next_st.wHeld && !st.rsp.bvalid)
        begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = RESP_OKAY;
            if (addrIs(next_st.awAddr, ADDR_CTRL))
            begin
                if (next_st.wStrb[0])
                begin
                    next_st.ctrlEnable = next_st.wData[CTRL_EN];
                end
            end
            else if (addrIs(next_st.awAddr, ADDR_STATUS))
            begin
                if (next_st.wStrb[0])
                begin
                    clrBits = next_st.wData[3:0]; // write one to clear
                end
            end
            else if (addrIs(next_st.awAddr, ADDR_MASK))
            begin
                if (next_st.wStrb[0])
                begin
                    next_st.mask = next_st.wData[3:0];
                end
            end
            else if (!(addrIs(next_st.awAddr, ADDR_CAUSE) ||
                       addrIs(next_st.awAddr, ADDR_GAMUT) ||
                       addrIs(next_st.awAddr, ADDR_MDCV)))
            begin
                next_st.rsp.bresp = RESP_DECERR; // nothing mapped here
            end
        end
        // hold off new halves while one is parked or a response waits
        next_st.rsp.awready = !next_st.awHeld && !next_st.rsp.bvalid;
        next_st.rsp.wready = !next_st.wHeld && !next_st.rsp.bvalid;

        // --- read channel ---
        if (st.rsp.rvalid && axiReq.rready)
        begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && st.rsp.arready)
        begin
            hit = 1'b1;
            if (addrIs(axiReq.araddr, ADDR_CTRL))
            begin
                rd[CTRL_EN] = st.ctrlEnable;
            end
            else if (addrIs(axiReq.araddr, ADDR_STATUS))
            begin
                rd[3:0] = st.status;
            end
            else if (addrIs(axiReq.araddr, ADDR_MASK))
            begin
                rd[3:0] = st.mask;
            end
            else if (addrIs(axiReq.araddr, ADDR_CAUSE))
            begin
                rd[N_CAUSE-1:0] = st.cause;
            end
            else if (addrIs(axiReq.araddr, ADDR_GAMUT))
            begin
                rd[7:0] = st.gamutLast;
                rd[GAMUT_CLASS_LSB+:3] = st.gamutClass;
            end
            else if (addrIs(axiReq.araddr, ADDR_MDCV))
            begin
                rd[0] = st.mdcvHeld;
            end
            else
            begin
                hit = 1'b0; // unmapped: zero data, error answer
            end
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rdata = rd;
            next_st.rsp.rresp = hit ? RESP_OKAY : RESP_DECERR;
        end
        next_st.rsp.arready = !next_st.rsp.rvalid;

        // --- volume message capture; a same-cycle arrival is used at once ---
        if (mdcvValid)
        begin
            mdcvNow = mdcvIn;
            mdcvNowHeld = 1'b1;
            next_st.mdcv = mdcvIn;
            next_st.mdcvHeld = 1'b1;
        end

        // --- field checks ---
        gClass = decodeGamut(msgIn.gamutMapMode);
        fails[CB_MODE] = msgIn.reconModeCode != REQ_MODE;
        fails[CB_MAJOR] = msgIn.specMajorRev != REQ_MAJOR;
        fails[CB_MINOR] = msgIn.specMinorRev != REQ_MINOR;
        fails[CB_PICINFO] = msgIn.codedPicInfoPresent;
        fails[CB_EXT] = msgIn.extPresentFlag;
        // absent target fields are not checked
        fails[CB_TMAX] = msgIn.targetInfoPresent &&
                         msgIn.targetMaxLum != REQ_TMAX;
        fails[CB_TMIN] = msgIn.targetInfoPresent &&
                         msgIn.targetMinLum != REQ_TMIN;
        fails[CB_CHROMA] = |chromaNz;
        fails[CB_LUMA] = |lumaNz;
        fails[CB_GAMUT] = gClass == GMC_INVALID;

        // outgoing copy: ignored fields cleared so they cannot leak
        fwdMsg.codedPrimaries = '0;
        fwdMsg.codedMaxLum = '0;
        fwdMsg.codedMinLum = '0;
        fwdMsg.extSixBitField = '0;
        fwdMsg.extPayloadCount = '0;
        // merge the received volume when the message lacks one
        if (!msgIn.mdcvPresent && mdcvNowHeld)
        begin
            fwdMsg.mdcv = mdcvNow;
            fwdMsg.mdcvPresent = 1'b1;
        end

        // --- message disposition; disabled checker ignores input ---
        if (msgValid && st.ctrlEnable)
        begin
            if (msgIn.inAvc)
            begin
                setBits[ST_AVC] = 1'b1; // refused unchecked
            end
            else
            begin
                next_st.cause = fails;
                next_st.gamutLast = msgIn.gamutMapMode;
                next_st.gamutClass = gClass;
                if (|fails)
                begin
                    // nonconforming messages never go out
                    setBits[ST_NONCONF] = 1'b1;
                    next_st.checkFail = 1'b1;
                end
                else if (msgIn.carriageModeSel == CARRIAGE_PARAM)
                begin
                    next_st.msgOut = fwdMsg;
                    next_st.msgOutValid = 1'b1;
                    setBits[ST_FWD] = 1'b1;
                end
                else
                begin
                    setBits[ST_TABLE] = 1'b1; // table mode dropped
                end
            end
        end

        // set beats a clear in the same cycle, so no event is lost
        next_st.status = (st.status & ~clrBits) | setBits;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st <= '0;
            st.ctrlEnable <= CTRL_EN_RST;
            st.status <= STATUS_RST;
            st.mask <= MASK_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign axiRsp = st.rsp;
    assign msgOutValid = st.msgOutValid;
    assign msgOut = st.msgOut;
    assign checkFail = st.checkFail;
    assign irq = st.irq;

endmodule : hdrmc_conformance

/* test/hdrmc_checker.sv */
`timescale 1ns/10ps
// ------------------------
// port checker for the conformance block
// ------------------------
module hdrmc_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus
    input wire hdrmc_pkg::hdrmc_axi_req_t axiReq,
    input wire hdrmc_pkg::hdrmc_axi_rsp_t axiRsp,
    // message path
    input wire logic msgValid,
    input wire hdrmc_pkg::hdrmc_msg_t msgIn,
    input wire logic mdcvValid,
    input wire hdrmc_pkg::hdrmc_mdcv_t mdcvIn,
    input wire logic msgOutValid,
    input wire hdrmc_pkg::hdrmc_msg_t msgOut,
    input wire logic checkFail,
    input wire logic irq
);
    import hdrmc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // message taken, forwarded on the next cycle
    sequence s_fwd;
        msgValid ##1 msgOutValid;
    endsequence
    // message taken, refused on the next cycle
    sequence s_fail;
        msgValid ##1 checkFail;
    endsequence
    property p_mode;
        s_fwd |-> $past(msgIn.reconModeCode) == 8'h01;
    endproperty
    a_mode: assert property (p_mode) else $error("forwarded bad mode");
    property p_rev;
        s_fwd |-> $past(msgIn.specMajorRev) == 4'h1 && $past(msgIn.specMinorRev) == 4'h0;
    endproperty
    a_rev: assert property (p_rev) else $error("forwarded bad revision");
    property p_flags;
        s_fwd |-> !$past(msgIn.codedPicInfoPresent) && !$past(msgIn.extPresentFlag);
    endproperty
    a_flags: assert property (p_flags) else $error("forwarded flag set");
    property p_target;
        s_fwd ##0 $past(msgIn.targetInfoPresent)
            |-> $past(msgIn.targetMaxLum) == 16'h0064 && $past(msgIn.targetMinLum) == 16'h0000;
    endproperty
    a_target: assert property (p_target) else $error("forwarded bad target");
    property p_ignored;
        s_fwd |-> msgOut.codedMaxLum == 16'h0000 && msgOut.extPayloadCount == 8'h00;
    endproperty
    a_ignored: assert property (p_ignored) else $error("ignored field leaked");
    property p_gamut;
        s_fwd |-> $past(msgIn.gamutMapMode) inside {[0:1], [4:5], [64:127]};
    endproperty
    a_gamut: assert property (p_gamut) else $error("forwarded bad selector");
    property p_avc;
        msgValid && msgIn.inAvc |=> !msgOutValid && !checkFail;
    endproperty
    a_avc: assert property (p_avc) else $error("avc message acted on");
    property p_carriage;
        s_fwd |-> $past(msgIn.carriageModeSel) == 1'b0;
    endproperty
    a_carriage: assert property (p_carriage) else $error("table mode forwarded");
    property p_own_volume;
        s_fwd ##0 $past(msgIn.mdcvPresent) |-> msgOut.mdcv == $past(msgIn.mdcv);
    endproperty
    a_own_volume: assert property (p_own_volume) else $error("own volume replaced");
    property p_fail;
        s_fail |-> !msgOutValid;
    endproperty
    a_fail: assert property (p_fail) else $error("failed message forwarded");
    property p_bresp;
        axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |=> axiRsp.bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response late");
    property p_rhold;
        axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule : hdrmc_checker

bind hdrmc_conformance hdrmc_checker i_chk (.clk(clk), .reset(reset), .axiReq(axiReq),
    .axiRsp(axiRsp), .msgValid(msgValid), .msgIn(msgIn), .mdcvValid(mdcvValid),
    .mdcvIn(mdcvIn), .msgOutValid(msgOutValid), .msgOut(msgOut), .checkFail(checkFail),
    .irq(irq));

/* test/hdrmc_tx_model.sv */
`timescale 1ns/10ps
// ------------------------
// display transmitter: takes every forwarded message
// ------------------------
module hdrmc_tx_model
(
    // clock
    input wire logic clk,
    // from the block
    input wire logic msgOutValid,
    input wire hdrmc_pkg::hdrmc_msg_t msgOut,
    // seen by the bench
    output int nRx,
    output hdrmc_pkg::hdrmc_msg_t lastRx
);
    import hdrmc_pkg::*;
    // no back-pressure, so a pulse is a message taken
    initial nRx = 0;
    always @(posedge clk)
    begin
        if (msgOutValid === 1'b1)
        begin
            nRx <= nRx + 1;
            lastRx <= msgOut;
        end
    end
endmodule : hdrmc_tx_model

/* test/hdr_metadata_conformance_tb.sv */
`timescale 1ns/10ps
module hdr_metadata_conformance_tb;
    import hdrmc_pkg::*;
    // ------------------------
    // stimulus, design and partner
    // ------------------------
    logic clk = '0, reset = '1, msgValid = '0, mdcvValid = '0, msgOutValid, checkFail, irq;
    logic held = '0, en = '1; // model: volume held, checker on
    hdrmc_axi_req_t axiReq = '0;
    hdrmc_axi_rsp_t axiRsp;
    hdrmc_msg_t msgIn = '0, msgOut, lastRx, m, lastE;
    hdrmc_mdcv_t mdcvIn = '0, heldV, md;
    int miscompares = 0, nChecks = 0, cyc = 0, nRx, nFwd = 0;
    logic [31:0] lf = 32'd74561; // generator state
    logic [31:0] st = '0; // status model
    int gv[10] = '{0, 1, 3, 4, 5, 6, 63, 64, 127, 128};
    hdrmc_conformance i_dut (.clk(clk), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp),
        .msgValid(msgValid), .msgIn(msgIn), .mdcvValid(mdcvValid), .mdcvIn(mdcvIn),
        .msgOutValid(msgOutValid), .msgOut(msgOut), .checkFail(checkFail), .irq(irq));
    hdrmc_tx_model i_tx (.clk(clk), .msgOutValid(msgOutValid), .msgOut(msgOut),
        .nRx(nRx), .lastRx(lastRx));
    always #20 clk = ~clk;
    // hang guard, far above the couple of hundred cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            miscompares++;
            conclude();
        end
    end
    // ------------------------
    // helpers
    // ------------------------
    function logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction : rnd
    task automatic conclude();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nChecks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic chkMsg(input hdrmc_msg_t g, input hdrmc_msg_t e);
        nChecks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chkMsg
    // conforming message, ignorable fields filled with noise
    function automatic hdrmc_msg_t good();
        hdrmc_msg_t g = '0;
        g.reconModeCode = 8'h01;
        g.specMajorRev = 4'h1;
        g.targetInfoPresent = 1'b1;
        g.targetMaxLum = 16'd100;
        g.codedPrimaries = 8'(rnd());
        g.codedMaxLum = 16'(rnd());
        g.codedMinLum = 16'(rnd());
        g.extSixBitField = 6'(rnd());
        g.extPayloadCount = 8'(rnd());
        return g;
    endfunction : good
    // failure bits a message should raise
    function automatic logic [31:0] causes(hdrmc_msg_t x);
        logic [31:0] c = '0;
        int g = x.gamutMapMode;
        c[0] = x.reconModeCode != 1;
        c[1] = x.specMajorRev != 1;
        c[2] = x.specMinorRev != 0;
        c[3] = x.codedPicInfoPresent;
        c[4] = x.extPresentFlag;
        c[5] = x.targetInfoPresent && x.targetMaxLum != 100;
        c[6] = x.targetInfoPresent && x.targetMinLum != 0;
        c[7] = x.chromaIntoLumaCoef != '0;
        c[8] = x.lumaWeightCoef != '0;
        c[9] = !(g <= 1 || g == 4 || g == 5 || (g >= 64 && g <= 127));
        return c;
    endfunction : causes
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hF;
        axiReq.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
        end
        while (axiRsp.bvalid !== 1'b1);
        axiReq.bready <= 1'b0;
        chk(axiRsp.bresp, er);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
        end
        while (axiRsp.rvalid !== 1'b1);
        axiReq.rready <= 1'b0;
        chk(axiRsp.rdata, ed);
        chk(axiRsp.rresp, er);
    endtask : axr
    // one message, optional volume alongside, answer checked next cycle
    task automatic send(input hdrmc_msg_t x, input logic mv, input hdrmc_mdcv_t v);
        hdrmc_msg_t e;
        logic [31:0] c;
        logic fwd, fail;
        @(posedge clk);
        msgValid <= 1'b1;
        msgIn <= x;
        mdcvValid <= mv;
        mdcvIn <= v;
        @(posedge clk);
        msgValid <= 1'b0;
        mdcvValid <= 1'b0;
        #1;
        if (mv) {held, heldV} = {1'b1, v};
        c = causes(x);
        fail = en && !x.inAvc && c != 0;
        fwd = en && !x.inAvc && c == 0 && !x.carriageModeSel;
        // status: table, avc, forwarded, failed
        if (en) st = st | {!x.inAvc && c == 0 && x.carriageModeSel, x.inAvc, fwd, fail};
        e = x;
        {e.codedPrimaries, e.codedMaxLum, e.codedMinLum} = '0;
        {e.extSixBitField, e.extPayloadCount} = '0;
        if (!x.mdcvPresent && held) {e.mdcvPresent, e.mdcv} = {1'b1, heldV};
        chk(msgOutValid, fwd);
        chk(checkFail, fail);
        if (fwd) chkMsg(msgOut, e);
        if (fwd) nFwd++;
        if (fwd) lastE = e;
    endtask : send
    // ------------------------
    // main sequence
    // ------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 0;
        axr(ADDR_CTRL, 32'h1, RESP_OKAY);
        axr(ADDR_MASK, 32'h0, RESP_OKAY);
        axr(ADDR_MDCV, 32'h0, RESP_OKAY);
        axr(8'h20, 32'h0, RESP_DECERR);
        axw(8'h24, rnd(), RESP_DECERR);
        // no volume held yet: passes through with only the ignored fields cleared
        send(good(), 1'b0, '0);
        // each check broken alone
        for (int i = 0; i < 10; i++)
        begin
            m = good();
            case (i)
                0: m.reconModeCode = 8'h00;
                1: m.specMajorRev = 4'h2;
                2: m.specMinorRev = 4'h1;
                3: m.codedPicInfoPresent = 1'b1;
                4: m.extPresentFlag = 1'b1;
                5: m.targetMaxLum = 16'd101;
                6: m.targetMinLum = 16'h0001;
                7: m.chromaIntoLumaCoef[1] = 16'h0001;
                8: m.lumaWeightCoef[2] = 16'h8000;
                default: m.gamutMapMode = 8'h02;
            endcase
            send(m, 1'b0, '0);
            axr(ADDR_CAUSE, 32'h1 << i, RESP_OKAY);
        end
        // target absent: its values do not count
        m = good();
        m.targetInfoPresent = 1'b0;
        m.targetMaxLum = 16'(rnd());
        send(m, 1'b0, '0);
        // selector table and preset class
        for (int k = 0; k < 10; k++)
        begin
            m = good();
            m.gamutMapMode = 8'(gv[k]);
            send(m, 1'b0, '0);
            axr(ADDR_GAMUT, gv[k] | ((gv[k] <= 1) ? 0 : (gv[k] == 4) ? 1 : (gv[k] == 5) ? 2 :
                (gv[k] >= 64 && gv[k] <= 127) ? 3 : 4) << 8, RESP_OKAY);
        end
        // avc carriage with a bad field, then table mode
        m = good();
        m.inAvc = 1'b1;
        m.reconModeCode = 8'h03;
        send(m, 1'b0, '0);
        axr(ADDR_STATUS, st, RESP_OKAY);
        m = good();
        m.carriageModeSel = 1'b1;
        send(m, 1'b0, '0);
        // volume merged, then a message carrying its own
        md = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        send(good(), 1'b1, md);
        m = good();
        m.mdcvPresent = 1'b1;
        m.mdcv = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        send(m, 1'b0, '0);
        axr(ADDR_MDCV, 32'h1, RESP_OKAY);
        // status, mask, interrupt, clear
        axr(ADDR_STATUS, st, RESP_OKAY);
        chk(irq, 1'b0);
        axw(ADDR_MASK, 32'h1, RESP_OKAY);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b1);
        axw(ADDR_STATUS, 32'h1, RESP_OKAY);
        st = st & 32'hE;
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b0);
        axr(ADDR_STATUS, st, RESP_OKAY);
        // disabled: a bad message is ignored
        axw(ADDR_CTRL, 32'h0, RESP_OKAY);
        en = 0;
        m = good();
        m.specMinorRev = 4'h7;
        send(m, 1'b0, '0);
        axr(ADDR_STATUS, st, RESP_OKAY);
        // reset mid-run clears the sticky bits
        @(posedge clk);
        reset <= 1;
        repeat (2) @(posedge clk);
        reset <= 0;
        en = 1;
        held = 0;
        st = 0;
        axr(ADDR_STATUS, 32'h0, RESP_OKAY);
        axr(ADDR_CTRL, 32'h1, RESP_OKAY);
        chk(nRx, nFwd);
        chkMsg(lastRx, lastE);
        conclude();
    end
endmodule : hdr_metadata_conformance_tb
